// *** srl_pkg.sv ***
package srl_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 8;
    localparam int unsigned LANES = 4;
    localparam logic [7:0] ADDR_RSVD_A = 8'h02;
    localparam logic [7:0] ADDR_RSVD_B = 8'h03;
    localparam logic [7:0] ADDR_RESET_LOAD = 8'h04;
    localparam logic [7:0] ADDR_LOAD_STATUS = 8'h05;
    localparam logic [7:0] ADDR_RSVD_C = 8'h06;
    localparam logic [7:0] ADDR_RSVD_D = 8'h07;
    localparam logic [7:0] ADDR_SELECT = 8'hff;
    localparam logic [7:0] RST_RSVD_A = 8'h00;
    localparam logic [7:0] RST_RSVD_B = 8'h00;
    localparam logic [7:0] RST_RESET_LOAD = 8'h01;
    localparam logic [7:0] RST_LOAD_CTRL = 8'h00;
    localparam logic [7:0] RST_RSVD_C = 8'h00;
    localparam logic [7:0] RST_RSVD_D = 8'h05;
    localparam logic [7:0] RST_SELECT = 8'h00;
    localparam int unsigned SEL_TARGET_LSB = 0;
    localparam int unsigned SEL_BANK_EN_BIT = 2;
    localparam int unsigned SEL_BCAST_BIT = 3;
    localparam int unsigned RL_BANK_RST_BIT = 6;
    localparam int unsigned RL_MAS_RST_BIT = 5;
    localparam int unsigned RL_FORCE_LOAD_BIT = 4;
    localparam int unsigned LS_DISABLE_BIT = 7;
    localparam int unsigned LS_DONE_BIT = 4;
    localparam logic [7:0] RL_RW_MASK = 8'h9f;
    localparam logic [7:0] LS_RW_MASK = 8'he0;
    localparam logic [7:0] UNDEF_READ = 8'h00;
    localparam int unsigned SC_PULSE_CYCLES = 1;
endpackage

// *** srl_lane_bank.sv ***
module srl_lane_bank #(
    parameter int unsigned DEPTH = 256
)(
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic                   wr_en,
    input  wire logic [srl_pkg::AW-1:0] addr,
    input  wire logic [srl_pkg::DW-1:0] wdata,
    output logic      [srl_pkg::DW-1:0] rdata
);
    import srl_pkg::*;

    // An eight-bit address cannot reach past 256 entries.
    if (DEPTH < 2 || DEPTH > 256)
    begin : g_bad_depth
        $error("srl_lane_bank: DEPTH out of range");
    end

    logic [DW-1:0] mem_q [DEPTH];

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= '0;
        end
        else if (wr_en && (int'(addr) < DEPTH))
            mem_q[addr] <= wdata;
    end

    assign rdata = (int'(addr) < DEPTH) ? mem_q[addr] : '0;
endmodule

// *** srl_shared_regs.sv ***
// Contract
// - Lane sets are reached only while select bit 2 is set.
// - Broadcast plus bank enable writes one address in all four lanes.
// - Lane reads always come from the lane in select bits 1:0.
// - Writes to 0xff always land in the select register.
// - Select register is not readable; reads return an undefined value.
// - Valid select values are 0x00, 0x04 to 0x07, 0x0c to 0x0f.
// - Bit 6 of 0x04 resets shared registers, then clears itself.
// - Bit 5 of 0x04 resets the EEPROM master logic, self clearing.
// - Bit 4 of 0x04 forces a configuration load from EEPROM.
// - Bit 7 of 0x05 disables EEPROM configuration loading.
// - Bit 4 of 0x05 reads one once the EEPROM load finished.
// - Bits 3:0 of 0x05 show lane 0 to 3 interrupts, reversed.
// - Writes to read-only bits are ignored.
// - Shared 0x00 is distinct from each lane's 0x00.
module srl_shared_regs #(
    parameter int unsigned LANE_DEPTH = 255
)(
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [srl_pkg::AW-1:0] reg_addr,
    input  wire logic [srl_pkg::DW-1:0] reg_wdata,
    input  wire logic [srl_pkg::LANES-1:0] lane_irq,
    input  wire logic                   load_done,
    output logic      [srl_pkg::DW-1:0] reg_rdata,
    output logic                        reg_rvalid,
    output logic                        force_config_load,
    output logic                        eeprom_master_reset,
    output logic                        config_load_disable
);
    import srl_pkg::*;

    // Address 0xff belongs to the select register, so no lane may own it.
    if (LANE_DEPTH < 8 || LANE_DEPTH > 255)
    begin : g_bad_depth
        $error("srl_shared_regs: LANE_DEPTH out of range");
    end

    logic [7:0] sel_q;
    logic [7:0] rsvd_a_q;
    logic [7:0] rsvd_b_q;
    logic [7:0] rl_q;
    logic [7:0] ls_q;
    logic [7:0] rsvd_c_q;
    logic [7:0] rsvd_d_q;
    logic [3:0] irq_s1_q;
    logic [3:0] irq_s2_q;
    logic [3:0] irq_s3_q;
    logic [3:0] irq_q;
    logic       done_s1_q;
    logic       done_s2_q;
    logic       done_s3_q;
    logic       done_q;
    logic       bank_rst;
    logic       lane_en;
    logic       lane_bcast;
    logic [1:0] lane_target_sel;
    logic       sel_wr;
    logic       shr_wr;
    logic [LANES-1:0] lane_wr;
    logic [DW-1:0]    lane_rd [LANES];
    logic [DW-1:0]    rdata_d;

    assign lane_en = sel_q[SEL_BANK_EN_BIT];
    assign lane_bcast = sel_q[SEL_BCAST_BIT];
    assign lane_target_sel = sel_q[SEL_TARGET_LSB +: 2];
    assign bank_rst = rl_q[RL_BANK_RST_BIT];
    assign sel_wr = reg_wr && (reg_addr == ADDR_SELECT);
    assign shr_wr = reg_wr && !lane_en && !sel_wr;

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            // Broadcast covers every lane; a lone write hits only the target.
            assign lane_wr[g] = reg_wr && lane_en && !sel_wr &&
                (lane_bcast || (lane_target_sel == 2'(g)));
            srl_lane_bank #(.DEPTH(LANE_DEPTH)) u_bank (
                .clock (clock),
                .rstn  (rstn),
                .wr_en (lane_wr[g]),
                .addr  (reg_addr),
                .wdata (reg_wdata),
                .rdata (lane_rd[g])
            );
        end
    endgenerate

    // The select register survives a shared-bank reset so the host keeps
    // its view of the bank while recovering.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            sel_q <= RST_SELECT;
        else if (sel_wr)
            sel_q <= reg_wdata;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            rsvd_a_q <= RST_RSVD_A;
            rsvd_b_q <= RST_RSVD_B;
            rsvd_c_q <= RST_RSVD_C;
            rsvd_d_q <= RST_RSVD_D;
        end
        else if (bank_rst)
        begin
            rsvd_a_q <= RST_RSVD_A;
            rsvd_b_q <= RST_RSVD_B;
            rsvd_c_q <= RST_RSVD_C;
            rsvd_d_q <= RST_RSVD_D;
        end
        else if (shr_wr)
        begin
            if (reg_addr == ADDR_RSVD_A)
                rsvd_a_q <= reg_wdata;
            if (reg_addr == ADDR_RSVD_C)
                rsvd_c_q <= reg_wdata;
            if (reg_addr == ADDR_RSVD_D)
                rsvd_d_q <= reg_wdata;
        end
    end

    // Self-clearing bits stand exactly one cycle; bank reset also clears
    // itself since it restores the defaults.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            rl_q <= RST_RESET_LOAD;
        else if (bank_rst)
            rl_q <= RST_RESET_LOAD;
        else if (shr_wr && reg_addr == ADDR_RESET_LOAD)
            rl_q <= reg_wdata & RL_RW_MASK |
                    (reg_wdata & ~RL_RW_MASK & 8'h60);
        else
        begin
            rl_q[RL_MAS_RST_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            ls_q <= RST_LOAD_CTRL;
        else if (bank_rst)
            ls_q <= RST_LOAD_CTRL;
        else if (shr_wr && reg_addr == ADDR_LOAD_STATUS)
            ls_q <= reg_wdata & LS_RW_MASK;
    end

    // Pins cross in through three flops; a change counts once two agree.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_s1_q  <= 4'h0;
            irq_s2_q  <= 4'h0;
            irq_s3_q  <= 4'h0;
            irq_q     <= 4'h0;
            done_s1_q <= 1'b1;
            done_s2_q <= 1'b1;
            done_s3_q <= 1'b1;
            done_q    <= 1'b1;
        end
        else
        begin
            irq_s1_q  <= lane_irq;
            irq_s2_q  <= irq_s1_q;
            irq_s3_q  <= irq_s2_q;
            for (int i = 0; i < LANES; i++)
                if (irq_s2_q[i] == irq_s3_q[i])
                    irq_q[i] <= irq_s3_q[i];
            done_s1_q <= load_done;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            if (done_s2_q == done_s3_q)
                done_q <= done_s3_q;
        end
    end

    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_addr == ADDR_SELECT)
            rdata_d = UNDEF_READ;
        else if (lane_en)
            rdata_d = lane_rd[lane_target_sel];
        else
        begin
            case (reg_addr)
                ADDR_RSVD_A:      rdata_d = rsvd_a_q;
                ADDR_RSVD_B:      rdata_d = rsvd_b_q;
                ADDR_RESET_LOAD:  rdata_d = rl_q;
                ADDR_LOAD_STATUS: rdata_d = {ls_q[7:5], done_q,
                    irq_q[0], irq_q[1], irq_q[2], irq_q[3]};
                ADDR_RSVD_C:      rdata_d = rsvd_c_q;
                ADDR_RSVD_D:      rdata_d = rsvd_d_q;
                default:          rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rdata_d;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            force_config_load   <= 1'b0;
            eeprom_master_reset <= 1'b0;
            config_load_disable <= 1'b0;
        end
        else
        begin
            force_config_load   <= rl_q[RL_FORCE_LOAD_BIT];
            eeprom_master_reset <= rl_q[RL_MAS_RST_BIT];
            config_load_disable <= ls_q[LS_DISABLE_BIT];
        end
    end

    sel_lands_a: assert property (@(posedge clock)
        disable iff (!rstn) reg_wr && reg_addr == ADDR_SELECT
        |=> sel_q == $past(reg_wdata)) else $error("select write lost");
    bcast_all_a: assert property (@(posedge clock)
        disable iff (!rstn) reg_wr && lane_en && lane_bcast && !sel_wr
        |-> lane_wr == 4'hf) else $error("broadcast missed a lane");
    shared_gate_a: assert property (@(posedge clock)
        disable iff (!rstn) !lane_en |-> lane_wr == 4'h0)
        else $error("lane written while disabled");
    read_lane_a: assert property (@(posedge clock)
        disable iff (!rstn) reg_rd && lane_en && reg_addr != ADDR_SELECT
        |=> reg_rdata == $past(lane_rd[lane_target_sel]))
        else $error("lane read wrong");
    bank_sc_a: assert property (@(posedge clock)
        disable iff (!rstn) bank_rst |=> !bank_rst && rsvd_d_q == RST_RSVD_D)
        else $error("bank reset stuck");
    mas_sc_a: assert property (@(posedge clock)
        disable iff (!rstn) rl_q[RL_MAS_RST_BIT]
        |=> eeprom_master_reset ##1 !eeprom_master_reset)
        else $error("master reset stuck");
    ro_ignore_a: assert property (@(posedge clock)
        disable iff (!rstn) ls_q[4:0] == 5'h00)
        else $error("read-only bits written");
    disable_out_a: assert property (@(posedge clock)
        disable iff (!rstn)
        ##1 config_load_disable == $past(ls_q[LS_DISABLE_BIT]))
        else $error("disable output wrong");
endmodule

// *** srl_eeprom_model.sv ***
module srl_eeprom_model
#(
    parameter int unsigned LOAD_CYCLES = 24
)(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic force_config_load,
    input  wire logic config_load_disable,
    input  wire logic eeprom_master_reset,
    output logic      load_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       force_q;
    logic [7:0] cnt_q;
    // Only a rising request starts a load, so a level left high loads once.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            force_q   <= 1'b0;
            cnt_q     <= 8'h00;
            load_done <= 1'b1;
        end
        else
        begin
            force_q <= force_config_load;
            if (eeprom_master_reset)
            begin
                cnt_q     <= 8'h00;
                load_done <= 1'b1;
            end
            else if (force_config_load && !force_q &&
                     !config_load_disable)
            begin
                cnt_q     <= 8'(LOAD_CYCLES);
                load_done <= 1'b0;
            end
            else if (cnt_q != 8'h00)
            begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01)
                    load_done <= 1'b1;
            end
        end
    end
endmodule

// *** srl_tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import srl_pkg::*;
    logic       clock, rstn, reg_wr, reg_rd, load_done, seen;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, a, d;
    logic [3:0] lane_irq;
    logic       reg_rvalid, force_config_load;
    logic       eeprom_master_reset, config_load_disable;
    int         n_errors, check_count, t, l, k;

    srl_shared_regs dut_u (.clock(clock), .rstn(rstn), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .lane_irq(lane_irq), .load_done(load_done), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .force_config_load(force_config_load),
        .eeprom_master_reset(eeprom_master_reset),
        .config_load_disable(config_load_disable));
    srl_eeprom_model ee_u (.clock(clock), .rstn(rstn),
        .force_config_load(force_config_load),
        .config_load_disable(config_load_disable),
        .eeprom_master_reset(eeprom_master_reset), .load_done(load_done));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
        @(negedge clock);
        reg_wr    = 1'b1;
        reg_addr  = wa;
        reg_wdata = wd;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    // Waits a bounded time for the answer so a dead read cannot hang.
    task automatic rchk(input string nm, input logic [7:0] ra,
                        input logic [7:0] e);
        int i;
        @(negedge clock);
        reg_rd   = 1'b1;
        reg_addr = ra;
        @(negedge clock);
        reg_rd = 1'b0;
        for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
            @(negedge clock);
        chk("rvalid", 8'h01, {7'h00, reg_rvalid});
        chk(nm, e, reg_rdata);
    endtask

    function automatic logic [7:0] stat(input logic dis, input logic dn,
                                        input logic [3:0] irq);
        return {dis, 2'b00, dn, irq[0], irq[1], irq[2], irq[3]};
    endfunction

    initial
    begin
        n_errors = 0;
        check_count = 0;
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        lane_irq = 4'h0;
        k = $urandom(32'hc2c0);
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        rchk("rsvd_a", ADDR_RSVD_A, RST_RSVD_A);
        rchk("rsvd_b", ADDR_RSVD_B, RST_RSVD_B);
        rchk("reset_load", ADDR_RESET_LOAD, RST_RESET_LOAD);
        rchk("status", ADDR_LOAD_STATUS, stat(0, 1, 0));
        rchk("rsvd_c", ADDR_RSVD_C, RST_RSVD_C);
        rchk("rsvd_d", ADDR_RSVD_D, RST_RSVD_D);
        rchk("select", ADDR_SELECT, UNDEF_READ);
        wr(ADDR_RSVD_B, 8'hff);
        rchk("rsvd_b", ADDR_RSVD_B, 8'h00);
        wr(ADDR_RSVD_A, 8'ha5);
        wr(ADDR_SELECT, 8'h04);
        wr(ADDR_RSVD_A, 8'h3c);
        rchk("lane0", ADDR_RSVD_A, 8'h3c);
        wr(ADDR_SELECT, 8'h00);
        rchk("shared", ADDR_RSVD_A, 8'ha5);
        for (k = 0; k < 6; k++)
        begin
            a = (k == 0) ? 8'hfe : 8'($urandom % 255);
            d = 8'($urandom);
            t = $urandom % 4;
            wr(ADDR_SELECT, 8'h0c | 8'(t));
            wr(a, d);
            wr(ADDR_SELECT, 8'h04 | 8'(t));
            wr(a, ~d);
            for (l = 0; l < 4; l++)
            begin
                wr(ADDR_SELECT, 8'h0c | 8'(l));
                rchk("lane", a, (l == t) ? ~d : d);
            end
        end
        wr(ADDR_SELECT, 8'h00);
        for (k = 0; k < 5; k++)
        begin
            lane_irq = (k == 0) ? 4'h1 : 4'($urandom);
            repeat (5) @(negedge clock);
            rchk("irq", ADDR_LOAD_STATUS, stat(0, 1, lane_irq));
        end
        lane_irq = 4'h0;
        repeat (5) @(negedge clock);
        wr(ADDR_LOAD_STATUS, 8'h9f);
        rchk("status", ADDR_LOAD_STATUS, stat(1, 1, 0));
        chk("disable", 8'h01, {7'h00, config_load_disable});
        wr(ADDR_RESET_LOAD, 8'h11);
        @(negedge clock);
        chk("force", 8'h01, {7'h00, force_config_load});
        repeat (30) @(negedge clock);
        rchk("status", ADDR_LOAD_STATUS, stat(1, 1, 0));
        wr(ADDR_LOAD_STATUS, 8'h00);
        wr(ADDR_RESET_LOAD, 8'h01);
        wr(ADDR_RESET_LOAD, 8'h11);
        repeat (6) @(negedge clock);
        rchk("loading", ADDR_LOAD_STATUS, stat(0, 0, 0));
        repeat (30) @(negedge clock);
        rchk("loaded", ADDR_LOAD_STATUS, stat(0, 1, 0));
        wr(ADDR_RESET_LOAD, 8'h21);
        seen = 1'b0;
        repeat (3)
        begin
            if (eeprom_master_reset === 1'b1)
                seen = 1'b1;
            @(negedge clock);
        end
        chk("master_reset", 8'h01, {7'h00, seen});
        rchk("reset_load", ADDR_RESET_LOAD, 8'h01);
        wr(ADDR_RSVD_A, 8'h77);
        wr(ADDR_RSVD_D, 8'h12);
        wr(ADDR_LOAD_STATUS, 8'h80);
        wr(ADDR_RESET_LOAD, 8'h41);
        rchk("reset_load", ADDR_RESET_LOAD, RST_RESET_LOAD);
        rchk("rsvd_a", ADDR_RSVD_A, RST_RSVD_A);
        rchk("rsvd_d", ADDR_RSVD_D, RST_RSVD_D);
        rchk("status", ADDR_LOAD_STATUS, stat(0, 1, 0));
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule
